/* File: fsp_pkg.sv */
// fsp_pkg: constants, types and register map of the boot-block flash sequencer host.
// assumes a 10 MHz pclk and a word-wide (x16) flash bus with an 18-bit word address.
package fsp_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS      = 100;
    localparam int T_WP_NS     = 100;  // least write strobe width
    localparam int T_ACC_NS    = 150;  // least read access before data is taken
    localparam int T_REC_NS    = 100;  // least strobe-high recovery
    localparam int SYNC_STAGES = 2;
    localparam int WE_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC     = (T_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC      = ACC_CYC + SYNC_STAGES;
    localparam int PH_LAST_INT = RD_CYC + REC_CYC - 1;
    localparam logic [3:0] PH_WE   = 4'(WE_CYC);
    localparam logic [3:0] PH_RD   = 4'(RD_CYC);
    localparam logic [3:0] PH_WEND = 4'(WE_CYC + REC_CYC - 1);
    localparam logic [3:0] PH_CAP  = 4'(RD_CYC - 1);
    localparam logic [3:0] PH_REND = 4'(PH_LAST_INT);

    // ****************************************
    // flash command codes and status bits
    // ****************************************
    localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_PROG_SETUP    = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT      = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
    localparam int SB_READY      = 7;
    localparam int SB_SUSPENDED  = 6;
    localparam int SB_ERASE_FAIL = 5;
    localparam int SB_PROG_FAIL  = 4;

    // ****************************************
    // apb register map
    // ****************************************
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_PINS  = 8'h0c;
    localparam logic [7:0] REG_STAT  = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;
    localparam int CTRL_ALT_BIT = 4;
    localparam logic [3:0] PINS_RST = 4'h0;
    localparam logic [3:0] OP_READ       = 4'h1;
    localparam logic [3:0] OP_RD_ARRAY   = 4'h2;
    localparam logic [3:0] OP_RD_STATUS  = 4'h3;
    localparam logic [3:0] OP_CLEAR      = 4'h4;
    localparam logic [3:0] OP_PROG       = 4'h5;
    localparam logic [3:0] OP_ERASE      = 4'h6;
    localparam logic [3:0] OP_SUSPEND    = 4'h7;
    localparam logic [3:0] OP_RESUME     = 4'h8;
    localparam int FL_ADDR_W = 18;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_W1   = 6'b000010,
        S_W2   = 6'b000100,
        S_W3   = 6'b001000,
        S_POLL = 6'b010000,
        S_RD   = 6'b100000
    } fsp_state_e;

    typedef struct packed {
        logic                 vpp_en;
        logic                 wp_n;
        logic                 rp_hv;
        logic                 rp_n;
    } fsp_pins_s;

    typedef struct packed {
        logic [FL_ADDR_W-1:0] a;
        logic [15:0]          dq_o;
        logic                 dq_oe;
        logic                 ce_n;
        logic                 oe_n;
        logic                 we_n;
    } fsp_flash_s;

    typedef struct packed {
        fsp_state_e           st;
        logic [3:0]           ph;
        logic [3:0]           op;
        logic                 alt;
        logic [FL_ADDR_W-1:0] addr;
        logic [15:0]          wdata;
        fsp_pins_s            pins;
        logic [7:0]           status;
        logic [15:0]          rdata;
        logic [15:0]          sy1;
        logic [15:0]          sy2;
        fsp_flash_s           fl;
        logic [31:0]          prdata;
        logic                 pslverr;
    } fsp_regs_s;

endpackage

/* File: fsp_host.sv */
// fsp_host: apb-programmed host that sequences program, erase, suspend and status polls on a boot-block flash.
// assumes the flash pins are asynchronous to pclk and the flash obeys its own command interface.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module fsp_host #(
    parameter logic [7:0] CMD_SUSPEND = 8'hb0,
    parameter logic [7:0] CMD_RESUME  = 8'hd0
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // flash bus
    output fsp_pkg::fsp_flash_s     flash_bus,
    input  wire logic [15:0]        flash_dq,
    // flash control pins
    output fsp_pkg::fsp_pins_s      flash_ctl
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (fsp_pkg::PH_LAST_INT > 15) begin : g_chk_ph
        $error("phase counter too narrow for the bus timing");
    end
    if (CMD_SUSPEND == CMD_RESUME) begin : g_chk_cmd
        $error("suspend and resume codes must differ");
    end

    // ****************************************
    // helpers
    // ****************************************
    fsp_pkg::fsp_regs_s q;
    fsp_pkg::fsp_regs_s d;
    logic               busy;
    logic               susp_ok;
    logic               start_ok;
    logic               wr_st;
    logic               rd_st;

    function automatic logic [7:0] first_code(input logic [3:0] op, input logic alt);
        case (op)
            fsp_pkg::OP_RD_STATUS: first_code = fsp_pkg::CMD_READ_STATUS;
            fsp_pkg::OP_CLEAR:     first_code = fsp_pkg::CMD_CLEAR_STATUS;
            fsp_pkg::OP_PROG:      first_code = alt ? fsp_pkg::CMD_PROG_ALT : fsp_pkg::CMD_PROG_SETUP;
            fsp_pkg::OP_ERASE:     first_code = fsp_pkg::CMD_ERASE_SETUP;
            fsp_pkg::OP_SUSPEND:   first_code = CMD_SUSPEND;
            fsp_pkg::OP_RESUME:    first_code = CMD_RESUME;
            default:               first_code = fsp_pkg::CMD_READ_ARRAY;
        endcase
    endfunction

    function automatic logic op_allowed(input logic [3:0] op, input logic susp);
        // a suspended erase admits only reads and resume
        if (susp) begin
            op_allowed = (op == fsp_pkg::OP_READ) || (op == fsp_pkg::OP_RD_ARRAY) ||
                         (op == fsp_pkg::OP_RD_STATUS) || (op == fsp_pkg::OP_RESUME);
        end else begin
            op_allowed = (op >= fsp_pkg::OP_READ) && (op <= fsp_pkg::OP_RESUME);
        end
    endfunction

    assign busy     = (q.st != fsp_pkg::S_IDLE);
    // suspend may cut into an erase poll, never in the cycle that closes a poll,
    // so a poll still ends either in a fresh poll or in an idle cycle
    assign susp_ok  = (q.st == fsp_pkg::S_POLL) && (q.op == fsp_pkg::OP_ERASE) &&
                      (q.ph < fsp_pkg::PH_CAP) && (pwdata[3:0] == fsp_pkg::OP_SUSPEND);
    // device held in reset would never answer a poll, so refuse
    assign start_ok = (!busy || susp_ok) && q.pins.rp_n &&
                      op_allowed(pwdata[3:0], q.status[fsp_pkg::SB_SUSPENDED]);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d     = q;
        wr_st = 1'b0;
        rd_st = 1'b0;
        d.sy1 = flash_dq;
        d.sy2 = q.sy1;

        case (q.st)
            fsp_pkg::S_W1, fsp_pkg::S_W2, fsp_pkg::S_W3: begin
                d.ph = q.ph + 4'h1;
                if (q.ph == fsp_pkg::PH_WEND) begin
                    d.ph = 4'h0;
                    if (q.st == fsp_pkg::S_W3) begin
                        d.st = fsp_pkg::S_POLL;
                    end else if (q.st == fsp_pkg::S_W2) begin
                        d.st = fsp_pkg::S_W3;
                    end else if (q.op == fsp_pkg::OP_PROG || q.op == fsp_pkg::OP_ERASE) begin
                        d.st = fsp_pkg::S_W2;
                    end else if (q.op == fsp_pkg::OP_SUSPEND || q.op == fsp_pkg::OP_RESUME) begin
                        d.st = fsp_pkg::S_W3;
                    end else begin
                        d.st = fsp_pkg::S_IDLE;
                    end
                end
            end
            fsp_pkg::S_POLL, fsp_pkg::S_RD: begin
                d.ph = q.ph + 4'h1;
                if (q.ph == fsp_pkg::PH_CAP) begin
                    d.rdata = q.sy2;
                    if (q.st == fsp_pkg::S_POLL) begin
                        d.status = q.sy2[7:0];
                    end
                end
                if (q.ph == fsp_pkg::PH_REND) begin
                    d.ph = 4'h0;
                    // keep polling until the engine reports ready
                    if (q.st == fsp_pkg::S_POLL && !q.status[fsp_pkg::SB_READY]) begin
                        d.st = fsp_pkg::S_POLL;
                    end else begin
                        d.st = fsp_pkg::S_IDLE;
                    end
                end
            end
            default: begin
                d.st = fsp_pkg::S_IDLE;
                d.ph = 4'h0;
            end
        endcase

        // apb setup phase: answer and refusal decided here, held for the access phase
        if (psel && !penable) begin
            d.pslverr = 1'b0;
            d.prdata  = 32'h0;
            case (paddr)
                fsp_pkg::REG_CTRL: begin
                    d.pslverr = pwrite && !start_ok;
                    d.prdata  = {27'h0, q.alt, q.op};
                end
                fsp_pkg::REG_ADDR:  d.prdata = {14'h0, q.addr};
                fsp_pkg::REG_WDATA: d.prdata = {16'h0, q.wdata};
                fsp_pkg::REG_PINS:  d.prdata = {28'h0, q.pins};
                fsp_pkg::REG_STAT: begin
                    d.pslverr = pwrite;
                    d.prdata  = {16'h0, q.status[7:3], 3'h0, 5'h0,
                                 q.status[fsp_pkg::SB_SUSPENDED],
                                 q.status[fsp_pkg::SB_PROG_FAIL] & q.status[fsp_pkg::SB_ERASE_FAIL],
                                 busy};
                end
                fsp_pkg::REG_RDATA: begin
                    d.pslverr = pwrite;
                    d.prdata  = {16'h0, q.rdata};
                end
                default: d.pslverr = 1'b1;
            endcase
        end

        // apb access phase: writes take effect here
        if (psel && penable && pwrite && !q.pslverr) begin
            case (paddr)
                fsp_pkg::REG_CTRL: begin
                    d.op  = pwdata[3:0];
                    d.alt = pwdata[fsp_pkg::CTRL_ALT_BIT];
                    d.ph  = 4'h0;
                    d.st  = (pwdata[3:0] == fsp_pkg::OP_READ) ? fsp_pkg::S_RD : fsp_pkg::S_W1;
                end
                fsp_pkg::REG_ADDR:  d.addr  = pwdata[fsp_pkg::FL_ADDR_W-1:0];
                fsp_pkg::REG_WDATA: d.wdata = pwdata[15:0];
                fsp_pkg::REG_PINS:  d.pins  = fsp_pkg::fsp_pins_s'(pwdata[3:0]);
                default: d.pins = q.pins;
            endcase
        end

        // bus strobes follow the next state so they line up with it
        wr_st       = (d.st == fsp_pkg::S_W1) || (d.st == fsp_pkg::S_W2) || (d.st == fsp_pkg::S_W3);
        rd_st       = (d.st == fsp_pkg::S_POLL) || (d.st == fsp_pkg::S_RD);
        d.fl.a      = d.addr;
        d.fl.dq_oe  = wr_st;
        d.fl.we_n   = !(wr_st && d.ph < fsp_pkg::PH_WE);
        d.fl.oe_n   = !(rd_st && d.ph < fsp_pkg::PH_RD);
        d.fl.ce_n   = d.fl.we_n && d.fl.oe_n;
        if (d.st == fsp_pkg::S_W3) begin
            d.fl.dq_o = {8'h0, fsp_pkg::CMD_READ_STATUS};
        end else if (d.st == fsp_pkg::S_W2) begin
            d.fl.dq_o = (d.op == fsp_pkg::OP_PROG) ? d.wdata : {8'h0, fsp_pkg::CMD_ERASE_CONFIRM};
        end else if (d.st == fsp_pkg::S_W1) begin
            d.fl.dq_o = {8'h0, first_code(d.op, d.alt)};
        end else begin
            d.fl.dq_o = 16'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            q.st      <= fsp_pkg::S_IDLE;
            q.pins    <= fsp_pkg::PINS_RST;
            q.fl.ce_n <= 1'b1;
            q.fl.oe_n <= 1'b1;
            q.fl.we_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata    = q.prdata;
    assign pslverr   = q.pslverr;
    assign pready    = 1'b1;
    assign flash_bus = q.fl;
    assign flash_ctl = q.pins;

    // ****************************************
    // assertions
    // ****************************************
    AST_POLL_FRESH_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == fsp_pkg::S_POLL && q.ph == 4'h0) |-> $fell(q.fl.oe_n) && $fell(q.fl.ce_n))
        else $error("status poll started without a fresh strobe edge");
    AST_NO_WE_OE_CLASH: assert property (@(posedge pclk) disable iff (!presetn)
        !(!q.fl.we_n && !q.fl.oe_n))
        else $error("write and output enable low together");
    AST_PROG_SETUP_CODE: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == fsp_pkg::S_W1 && q.op == fsp_pkg::OP_PROG && !q.fl.we_n) |->
        q.fl.dq_o[7:0] == (q.alt ? fsp_pkg::CMD_PROG_ALT : fsp_pkg::CMD_PROG_SETUP))
        else $error("wrong program setup code");
    AST_PROG_TWO_WRITES: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == fsp_pkg::S_W1 && q.op == fsp_pkg::OP_PROG && q.ph == fsp_pkg::PH_WEND) |=>
        (q.st == fsp_pkg::S_W2 && !q.fl.we_n && q.fl.dq_o == q.wdata))
        else $error("program data write did not follow setup");
    AST_ERASE_IN_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (q.op == fsp_pkg::OP_ERASE && !q.fl.we_n && (q.st == fsp_pkg::S_W1 || q.st == fsp_pkg::S_W2)) |->
        q.fl.a == q.addr && q.fl.dq_o[7:0] == ((q.st == fsp_pkg::S_W1) ? fsp_pkg::CMD_ERASE_SETUP
                                                                       : fsp_pkg::CMD_ERASE_CONFIRM))
        else $error("erase write off block or wrong code");
    AST_ONLY_STATUS_WHILE_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == fsp_pkg::S_POLL) |-> q.fl.we_n && !q.fl.dq_oe)
        else $error("write issued while the engine is busy");
    AST_POLL_UNTIL_READY: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == fsp_pkg::S_POLL && q.ph == fsp_pkg::PH_REND && !q.status[fsp_pkg::SB_READY]) |=>
        (q.st == fsp_pkg::S_POLL && q.ph == 4'h0 && busy))
        else $error("poll ended before the engine was ready");
    AST_READY_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == fsp_pkg::S_POLL && q.ph == fsp_pkg::PH_REND && q.status[fsp_pkg::SB_READY]) |=>
        !busy ##1 q.fl.ce_n)
        else $error("sequence did not end on ready");
    AST_RESUME_SELECTED: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == fsp_pkg::S_W1 && q.op == fsp_pkg::OP_RESUME && !q.fl.we_n) |->
        !q.fl.ce_n && q.fl.dq_o[7:0] == CMD_RESUME)
        else $error("resume written without chip select");
    AST_SUSPEND_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite && paddr == fsp_pkg::REG_CTRL && q.status[fsp_pkg::SB_SUSPENDED] &&
         (pwdata[3:0] == fsp_pkg::OP_PROG || pwdata[3:0] == fsp_pkg::OP_ERASE)) |=> pslverr)
        else $error("forbidden command accepted during suspend");

endmodule // fsp_host

`default_nettype wire

/* File: fsp_flash_model.sv */
// fsp_flash_model: behavioural boot-block flash on the far side of the host's pins.
// assumes the host moves its strobes on pclk edges; engine time is counted in pclk cycles.
`timescale 1ns/100ps
`default_nettype none

module fsp_flash_model #(
    parameter int PROG_CYC  = 3,
    parameter int ERASE_CYC = 12
) (
    input  wire  pclk,
    input  wire  fsp_pkg::fsp_flash_s bus,
    input  wire  fsp_pkg::fsp_pins_s  ctl,
    output logic [15:0]               dq
);
    logic [15:0] mem [0:262143];
    logic [7:0]  sr      = 8'h80;
    logic [7:0]  sr_lat  = 8'h80;
    logic [4:0]  eblk    = 5'h00;
    logic        st_mode = 1'b0;
    logic        setup_p = 1'b0;
    logic        setup_e = 1'b0;
    logic        erasing = 1'b0;
    logic        prev_rd = 1'b0;
    int          busy    = 0;

    // boot block is the top 8k words
    function automatic logic locked(input logic [17:0] a);
        return !ctl.rp_n || (!ctl.wp_n && !ctl.rp_hv && a[17:13] == 5'h1f);
    endfunction

    initial begin
        dq = 16'h5a5a;
        for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
    end

    always @(posedge pclk) begin
        logic [7:0] d;
        logic       rd;
        rd = !bus.ce_n && !bus.oe_n;
        d  = bus.dq_o[7:0];
        if (!ctl.rp_n) begin
            sr      = 8'h80;
            st_mode = 1'b0;
            setup_p = 1'b0;
            setup_e = 1'b0;
            busy    = 0;
        end else begin
            // engine stands still while suspended
            if (busy > 0 && !sr[6]) begin
                busy--;
                if (busy == 0) begin
                    sr[7] = 1'b1;
                    // zero-program phase folded into the timed wait; only the final ones show
                    if (erasing) for (int i = 0; i < 8192; i++) mem[{eblk, 13'(i)}] = 16'hffff;
                end
            end
            if (!bus.ce_n && !bus.we_n) begin
                if (setup_p) begin
                    setup_p = 1'b0;
                    st_mode = 1'b1;
                    if (!ctl.vpp_en) sr[3] = 1'b1;
                    else if (locked(bus.a)) sr[4] = 1'b1;
                    else begin
                        mem[bus.a] = mem[bus.a] & bus.dq_o;
                        sr[7]   = 1'b0;
                        erasing = 1'b0;
                        busy    = PROG_CYC;
                    end
                end else if (setup_e) begin
                    setup_e = 1'b0;
                    st_mode = 1'b1;
                    if (d != 8'hd0) sr = sr | 8'h30;
                    else if (!ctl.vpp_en) sr = sr | 8'h28;
                    else if (locked(bus.a)) sr = sr | 8'h20;
                    else begin
                        eblk    = bus.a[17:13];
                        sr[7]   = 1'b0;
                        erasing = 1'b1;
                        busy    = ERASE_CYC;
                    end
                end else if (busy > 0 || sr[6]) begin
                    if (d == 8'hb0 && erasing && !sr[6]) sr = sr | 8'hc0;
                    else if (d == 8'hd0 && sr[6]) sr = sr & 8'h3f;
                    st_mode = (d != 8'hff);
                end else begin
                    case (d)
                        8'hff:        st_mode = 1'b0;
                        8'h70:        st_mode = 1'b1;
                        8'h50:        sr = sr & 8'hc7;
                        8'h40, 8'h10: setup_p = 1'b1;
                        8'h20:        setup_e = 1'b1;
                        default:      ;
                    endcase
                end
            end
        end
        if (rd && !prev_rd) sr_lat = sr;
        prev_rd = rd;
        // released bus keeps changing so a stale value never looks valid
        dq <= !rd ? ~dq : (st_mode ? {8'h00, sr_lat & 8'hf8} : mem[bus.a]);
    end
endmodule // fsp_flash_model

`default_nettype wire

/* File: tb.sv */
// tb: self-checking bench for fsp_host against the behavioural flash model.
// assumes fsp_pkg is compiled first; apb answers with pready high.
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic                pready;
    logic                pslverr;
    logic                er;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic [31:0]         rv;
    logic [15:0]         flash_dq;
    fsp_pkg::fsp_flash_s flash_bus;
    fsp_pkg::fsp_pins_s  flash_ctl;
    logic [31:0]         seed = 32'h74b8;
    int                  failures = 0;
    int                  n_tests = 0;

    fsp_host dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_bus(flash_bus), .flash_dq(flash_dq), .flash_ctl(flash_ctl));
    // long erase leaves room to suspend from inside the erase poll
    fsp_flash_model #(.PROG_CYC(3), .ERASE_CYC(40)) flash_u (.pclk(pclk), .bus(flash_bus), .ctl(flash_ctl),
        .dq(flash_dq));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] exp_sr(input logic erase, input logic [3:0] pins, input logic boot);
        if (!pins[3]) return erase ? 8'ha8 : 8'h88;
        if (boot && !pins[2] && !pins[1]) return erase ? 8'ha0 : 8'h90;
        return 8'h80;
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one idle edge before each setup keeps every strobe at one assignment per step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rv = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(fsp_pkg::REG_STAT, 1'b0, 32'h0);
            n++;
        end while (rv[0] !== 1'b0 && n < 300);
        if (n >= 300) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic run(input logic [3:0] op, input logic alt);
        apb(fsp_pkg::REG_CTRL, 1'b1, {27'h0, alt, op});
        chk({31'h0, er}, 32'h0, "start accepted");
        wait_idle();
    endtask

    initial begin
        logic [3:0]  tbl [5];
        logic [31:0] r;
        logic [17:0] a;
        logic [15:0] m;
        logic [15:0] w;
        logic [7:0]  e;
        int          n;
        tbl     = '{4'h9, 4'hb, 4'hd, 4'h5, 4'h9};
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({28'h0, flash_ctl}, 32'h0, "pins after reset");
        chk({31'h0, flash_bus.ce_n}, 32'h1, "chip idle after reset");
        apb(8'h18, 1'b1, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped address");
        apb(fsp_pkg::REG_CTRL, 1'b1, 32'h3);
        chk({31'h0, er}, 32'h1, "start while flash held in reset");
        apb(fsp_pkg::REG_STAT, 1'b1, 32'h0);
        chk({31'h0, er}, 32'h1, "write to read-only status");
        apb(fsp_pkg::REG_PINS, 1'b1, 32'h9);
        apb(fsp_pkg::REG_CTRL, 1'b1, 32'h9);
        chk({31'h0, er}, 32'h1, "unknown op");
        $display("test refusals done");
        for (int j = 0; j < 5; j++) begin
            r = rnd();
            a = {(j < 3) ? 5'h1f : 5'h01, r[12:0]};
            m = 16'hffff;
            apb(fsp_pkg::REG_PINS, 1'b1, {28'h0, tbl[j]});
            apb(fsp_pkg::REG_ADDR, 1'b1, {14'h0, a});
            for (int k = 0; k < 3; k++) begin
                e = exp_sr(k == 2, tbl[j], j < 3);
                r = rnd();
                w = r[15:0];
                run(fsp_pkg::OP_CLEAR, 1'b0);
                chk({28'h0, flash_ctl}, {28'h0, tbl[j]}, "control pins");
                apb(fsp_pkg::REG_WDATA, 1'b1, {16'h0, w});
                run((k == 2) ? fsp_pkg::OP_ERASE : fsp_pkg::OP_PROG, k[0] ^ j[0]);
                if (e == 8'h80) m = (k == 2) ? 16'hffff : (m & w);
                chk({16'h0, rv[15:8], 8'h0}, {16'h0, e, 8'h0}, "polled status");
                chk({31'h0, rv[1]}, 32'h0, "no sequence error");
                run(fsp_pkg::OP_RD_STATUS, 1'b0);
                run(fsp_pkg::OP_READ, 1'b0);
                apb(fsp_pkg::REG_RDATA, 1'b0, 32'h0);
                chk(rv, {24'h0, e}, "status word read");
                run(fsp_pkg::OP_RD_ARRAY, 1'b0);
                run(fsp_pkg::OP_READ, 1'b0);
                apb(fsp_pkg::REG_RDATA, 1'b0, 32'h0);
                chk(rv, {16'h0, m}, "array word");
                run(fsp_pkg::OP_CLEAR, 1'b0);
                run(fsp_pkg::OP_RD_STATUS, 1'b0);
                run(fsp_pkg::OP_READ, 1'b0);
                apb(fsp_pkg::REG_RDATA, 1'b0, 32'h0);
                chk(rv, 32'h80, "status after clear");
            end
        end
        $display("test program, erase and locking done");
        apb(fsp_pkg::REG_PINS, 1'b1, 32'hd);
        r = rnd();
        a = {5'h03, r[12:0]};
        w = {1'b0, r[30:16]};
        apb(fsp_pkg::REG_WDATA, 1'b1, {16'h0, w});
        apb(fsp_pkg::REG_ADDR, 1'b1, {14'h0, 5'h02, r[12:0]});
        run(fsp_pkg::OP_PROG, 1'b0);
        apb(fsp_pkg::REG_ADDR, 1'b1, {14'h0, a});
        run(fsp_pkg::OP_PROG, 1'b0);
        apb(fsp_pkg::REG_ADDR, 1'b1, {14'h0, 5'h02, r[12:0]});
        apb(fsp_pkg::REG_CTRL, 1'b1, {28'h0, fsp_pkg::OP_ERASE});
        chk({31'h0, er}, 32'h0, "erase started");
        n = 0;
        do begin
            apb(fsp_pkg::REG_CTRL, 1'b1, {28'h0, fsp_pkg::OP_SUSPEND});
            n++;
        end while (er !== 1'b0 && n < 20);
        chk({31'h0, er}, 32'h0, "suspend taken inside erase poll");
        wait_idle();
        chk({16'h0, rv[15:8], 5'h0, rv[2:0]}, 32'h0000c004, "suspended status");
        apb(fsp_pkg::REG_CTRL, 1'b1, {28'h0, fsp_pkg::OP_PROG});
        chk({31'h0, er}, 32'h1, "program refused while suspended");
        run(fsp_pkg::OP_RD_ARRAY, 1'b0);
        apb(fsp_pkg::REG_ADDR, 1'b1, {14'h0, a});
        run(fsp_pkg::OP_READ, 1'b0);
        apb(fsp_pkg::REG_RDATA, 1'b0, 32'h0);
        chk(rv, {16'h0, w}, "other block read while suspended");
        run(fsp_pkg::OP_RESUME, 1'b0);
        chk({16'h0, rv[15:8], 5'h0, rv[2:0]}, 32'h00008000, "erase resumed to completion");
        apb(fsp_pkg::REG_ADDR, 1'b1, {14'h0, 5'h02, r[12:0]});
        run(fsp_pkg::OP_RD_ARRAY, 1'b0);
        run(fsp_pkg::OP_READ, 1'b0);
        apb(fsp_pkg::REG_RDATA, 1'b0, 32'h0);
        chk(rv, 32'hffff, "suspended block erased after resume");
        $display("test suspend and resume done");
        wrap_up();
    end
endmodule // tb

`default_nettype wire
